// [rtl/bsfm_top.sv]
// Sequencing, tracking, synchronisation and fault management of a buck converter.
`timescale 1ns/1ps
// How it works
// - Pre-biased start: no pull-down, same ramp
// - Disable ramps to off level, then tristate
// - Tracking off at reset, feature register enables
// - Tracking target is min of setting, track
// - Tracking target overrides off level when falling
// - Sync pin in/out via pin setup, off
// - Input lock only first 1ms or resync
// - Output mode drives own switching clock out
// - Warnings flag only; faults flag and respond
// - Alert drive selectable per warning and fault
// - Over-temperature ramps down softly at fall rate
// - Other faults switch off both power switches
// - Delay-to-fault rechecks; transient detections are discarded
// - Delay-to-retry waits, recheck, respond again
// - Retry delay is hundred times fault delay, or DTR register if that is zero
// - Retries zero to six; seven means hiccup
// - Protection uses raw current; report uses average
// - Default is zero delay and latch-off
// - Enable pin cycle clears a latched fault
// - Default: pin alone enables, command ignored
// - All alert enables set after reset
module bsfm_top #(
	parameter int MS_CYCLES_P = bsfm_pkg::MS_CYCLES,
	parameter int PWM_HALF_P = bsfm_pkg::PWM_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [bsfm_pkg::AW-1:0] addr,
	input wire logic [bsfm_pkg::DW-1:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [bsfm_pkg::DW-1:0] rdData,
	input wire logic enablePin,
	input wire logic [bsfm_pkg::VW-1:0] trackingVoltageInput,
	input wire logic [bsfm_pkg::VW-1:0] voutSense,
	input wire logic [bsfm_pkg::VW-1:0] currentSample,
	input wire logic [4:0] faultRaw,
	input wire logic [bsfm_pkg::NFLT-1:0] warnRaw,
	input wire logic syncIn,
	output logic syncOut,
	output logic syncOe,
	output logic syncLockEn,
	output logic [bsfm_pkg::VW-1:0] vSetpoint,
	output logic powerStageEn,
	output logic hiZ,
	output logic alertOut,
	output logic alertOe
);
	import bsfm_pkg::*;

	// ==========================================================
	// Helpers
	// Retry is allowed while attempts remain or in hiccup mode.
	function automatic logic retryOk(input logic [2:0] lim, input logic [2:0] done);
		retryOk = (lim == RETRY_INFINITE) || (done < lim);
	endfunction

	// Average filter: one eighth of the error is added per sample.
	function automatic logic [VW-1:0] avgStep(input logic [VW-1:0] avg,
		input logic [VW-1:0] s);
		logic signed [VW:0] diff;
		diff = $signed({1'b0, s}) - $signed({1'b0, avg});
		avgStep = avg + VW'(diff >>> 3);
	endfunction

	// ==========================================================
	// Registers and state
	logic [2:0] ctrlQ;
	logic trackEnQ;
	logic [1:0] syncModeQ;
	logic [VW-1:0] voutQ, voffQ, ocLimQ, ioutQ;
	logic [15:0] riseQ, fallQ;
	logic [10:0] fltCfgQ;
	logic [7:0] dtrQ;
	logic [11:0] alertEnQ, statusQ, statusD;
	bsfm_state_t stateQ, stateD;
	logic [2:0] retryCntQ;
	logic pendingQ, softQ, startedQ, enPrevQ, syncPwmQ;
	logic [31:0] msCntQ;
	logic [15:0] pwmCntQ;

	// ==========================================================
	// Decode and combinational terms
	logic wrCtrl, wrFeat, wrPin, wrVout, wrVoff, wrRise, wrFall;
	logic wrFlt, wrDtr, wrAlert, wrStat, wrOcl, resyncPulse, msTick;
	logic enableReq, faultAny, faultHit, softHit, active;
	logic [NFLT-1:0] faultNow;
	logic [2:0] retryLim;
	logic [7:0] dtfMs;
	logic [15:0] dtrEff;
	logic [VW-1:0] trackTarget, rampTarget, rampLevel;
	logic rampAt, rampRun, rampLoad, dtfDone, dtrDone, dtrStart, dtfStart;
	logic lockBusy, lockStart, fallDone, mapped;
	logic [DW-1:0] rdMux;

	assign wrCtrl = wrStb && addr == OFS_CTRL;
	assign wrFeat = wrStb && addr == OFS_FEATURE;
	assign wrPin = wrStb && addr == OFS_PINSETUP;
	assign wrVout = wrStb && addr == OFS_VOUT;
	assign wrVoff = wrStb && addr == OFS_VOFF;
	assign wrRise = wrStb && addr == OFS_RISE;
	assign wrFall = wrStb && addr == OFS_FALL;
	assign wrFlt = wrStb && addr == OFS_FLTCFG;
	assign wrDtr = wrStb && addr == OFS_DTR;
	assign wrAlert = wrStb && addr == OFS_ALERTEN;
	assign wrStat = wrStb && addr == OFS_STATUS;
	assign wrOcl = wrStb && addr == OFS_OCLIM;
	assign resyncPulse = wrCtrl && wrData[CTRL_RESYNC];
	assign msTick = (msCntQ == 32'(MS_CYCLES_P - 1));

	// Enable source: pin only unless the command path is selected.
	assign enableReq = ctrlQ[CTRL_USECMD] ? (enablePin && ctrlQ[CTRL_OPON]) : enablePin;

	// Over-current trips on the raw sample, not the average.
	assign faultNow = {faultRaw[4], currentSample > ocLimQ, faultRaw[3:0]};
	assign faultAny = |faultNow;
	assign retryLim = fltCfgQ[FLT_RETRY_LSB +: 3];
	assign dtfMs = fltCfgQ[FLT_DTF_LSB +: 8];
	assign dtrEff = (dtfMs != 8'h00) ? 16'(dtfMs) * DTR_FACTOR : 16'(dtrQ);
	assign active = (stateQ == ST_RISE) || (stateQ == ST_ON) ||
		(stateQ == ST_FALL && !softQ);

	// Qualified fault: at once with zero delay, else only if still present.
	assign faultHit = active && faultAny &&
		((dtfMs == 8'h00) || (pendingQ && dtfDone));
	assign dtfStart = active && faultAny && !pendingQ && dtfMs != 8'h00;
	assign softHit = faultNow[FI_OT] && !(|faultNow[FI_OC:0]);

	// Regulation target selection for each phase.
	assign trackTarget = (trackEnQ && trackingVoltageInput < voutQ) ?
		trackingVoltageInput : voutQ;
	assign rampTarget = (stateQ == ST_FALL) ?
		(trackEnQ ? trackTarget : voffQ) : trackTarget;
	assign rampRun = (stateQ == ST_RISE) || (stateQ == ST_ON) || (stateQ == ST_FALL);
	assign rampLoad = (stateQ == ST_OFF) || (stateQ == ST_RETRY) || (stateQ == ST_LATCH);
	assign fallDone = rampAt && (!trackEnQ || trackingVoltageInput == '0);

	// ==========================================================
	// State machine next state
	always_comb begin
		stateD = stateQ;
		dtrStart = 1'b0;
		case (stateQ)
			ST_OFF: begin
				if (enableReq)
					stateD = ST_RISE;
			end
			ST_RISE, ST_ON: begin
				if (faultHit && softHit) begin
					stateD = ST_FALL;
				end else if (faultHit) begin
					dtrStart = retryOk(retryLim, retryCntQ);
					stateD = dtrStart ? ST_RETRY : ST_LATCH;
				end else if (!enableReq) begin
					stateD = ST_FALL;
				end else if (stateQ == ST_RISE && rampAt) begin
					stateD = ST_ON;
				end
			end
			ST_FALL: begin
				if (faultHit && !softHit) begin
					dtrStart = retryOk(retryLim, retryCntQ);
					stateD = dtrStart ? ST_RETRY : ST_LATCH;
				end else if (softQ && rampAt) begin
					dtrStart = retryOk(retryLim, retryCntQ);
					stateD = dtrStart ? ST_RETRY : ST_LATCH;
				end else if (!softQ && fallDone) begin
					stateD = ST_OFF;
				end
			end
			ST_RETRY: begin
				if (!enableReq) begin
					stateD = ST_OFF;
				end else if (dtrDone && !faultAny) begin
					stateD = ST_RISE;
				end else if (dtrDone) begin
					dtrStart = retryOk(retryLim, retryCntQ + 3'h1);
					stateD = dtrStart ? ST_RETRY : ST_LATCH;
				end
			end
			ST_LATCH: begin
				if (!enablePin)
					stateD = ST_OFF;
			end
			default: stateD = ST_OFF;
		endcase
	end

	// ==========================================================
	// Sequencer flops
	// The retry count survives retries and resets only when fully off.
	always_ff @(posedge clk) begin
		if (rst) begin
			stateQ <= ST_OFF;
			retryCntQ <= 3'h0;
			softQ <= 1'b0;
			pendingQ <= 1'b0;
		end else begin
			stateQ <= stateD;
			if (stateQ == ST_OFF)
				retryCntQ <= 3'h0;
			else if (stateQ == ST_RETRY && dtrDone && retryLim != RETRY_INFINITE)
				retryCntQ <= retryCntQ + 3'h1;
			if (faultHit)
				softQ <= softHit;
			else if (stateD == ST_RISE)
				softQ <= 1'b0;
			// A detection that clears before the delay ends is dropped.
			if (!active || !faultAny || faultHit)
				pendingQ <= 1'b0;
			else if (dtfStart)
				pendingQ <= 1'b1;
		end
	end

	// ==========================================================
	// Power stage drive
	// Switching waits until the virtual ramp from zero meets the
	// pre-biased output, so the cap is never pulled down and the
	// rise time is unchanged.
	always_ff @(posedge clk) begin
		if (rst) begin
			startedQ <= 1'b0;
			powerStageEn <= 1'b0;
			hiZ <= 1'b1;
			vSetpoint <= '0;
		end else begin
			if (stateQ != ST_RISE)
				startedQ <= stateQ == ST_ON || stateQ == ST_FALL;
			else if (rampLevel >= voutSense)
				startedQ <= 1'b1;
			powerStageEn <= startedQ && rampRun && stateD != ST_RETRY &&
				stateD != ST_LATCH && stateD != ST_OFF;
			hiZ <= !(startedQ && rampRun && stateD != ST_RETRY &&
				stateD != ST_LATCH && stateD != ST_OFF);
			vSetpoint <= rampLevel;
		end
	end

	// ==========================================================
	// Dividers and synchronisation
	// Lock window opens on each enable and on a resync request.
	assign lockStart = (stateQ == ST_OFF && stateD == ST_RISE) ||
		(stateQ == ST_RETRY && stateD == ST_RISE) || resyncPulse;
	always_ff @(posedge clk) begin
		if (rst) begin
			msCntQ <= '0;
			pwmCntQ <= '0;
			syncPwmQ <= 1'b0;
			syncOut <= 1'b0;
			syncOe <= 1'b0;
			syncLockEn <= 1'b0;
		end else begin
			msCntQ <= msTick ? '0 : msCntQ + 32'h1;
			if (pwmCntQ == 16'(PWM_HALF_P - 1)) begin
				pwmCntQ <= '0;
				syncPwmQ <= !syncPwmQ;
			end else begin
				pwmCntQ <= pwmCntQ + 16'h1;
			end
			syncOut <= (syncModeQ == SYNC_OUT) && syncPwmQ;
			syncOe <= (syncModeQ == SYNC_OUT);
			syncLockEn <= (syncModeQ == SYNC_IN) && lockBusy && syncIn == syncIn;
		end
	end

	// ==========================================================
	// Register writes
	// Status bits are sticky; a new event wins over a clear.
	assign statusD = (statusQ & ~(wrStat ? wrData[11:0] : 12'h000)) |
		{faultNow, warnRaw};
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlQ <= RST_CTRL;
			trackEnQ <= 1'b0;
			syncModeQ <= SYNC_OFF;
			voutQ <= RST_VOUT;
			voffQ <= RST_VOFF;
			riseQ <= RST_STEP;
			fallQ <= RST_STEP;
			fltCfgQ <= RST_FLTCFG;
			dtrQ <= RST_DTR;
			alertEnQ <= RST_ALERTEN;
			ocLimQ <= RST_OCLIM;
			statusQ <= 12'h000;
			ioutQ <= '0;
			enPrevQ <= 1'b0;
		end else begin
			if (wrCtrl)
				ctrlQ <= {1'b0, wrData[CTRL_USECMD:CTRL_OPON]};
			if (wrFeat)
				trackEnQ <= wrData[FEAT_TRACK];
			if (wrPin)
				syncModeQ <= wrData[1:0];
			if (wrVout)
				voutQ <= wrData[VW-1:0];
			if (wrVoff)
				voffQ <= wrData[VW-1:0];
			if (wrRise)
				riseQ <= wrData;
			if (wrFall)
				fallQ <= wrData;
			if (wrFlt)
				fltCfgQ <= wrData[10:0];
			if (wrDtr)
				dtrQ <= wrData[7:0];
			if (wrAlert)
				alertEnQ <= wrData[11:0];
			if (wrOcl)
				ocLimQ <= wrData[VW-1:0];
			statusQ <= statusD;
			ioutQ <= avgStep(ioutQ, currentSample);
			enPrevQ <= enablePin;
		end
	end

	// ==========================================================
	// Read port and alert
	assign mapped = addr <= OFS_OCLIM;
	always_comb begin
		case (addr)
			OFS_CTRL: rdMux = {14'h0000, ctrlQ[1:0]};
			OFS_FEATURE: rdMux = {15'h0000, trackEnQ};
			OFS_PINSETUP: rdMux = {14'h0000, syncModeQ};
			OFS_VOUT: rdMux = {4'h0, voutQ};
			OFS_VOFF: rdMux = {4'h0, voffQ};
			OFS_RISE: rdMux = riseQ;
			OFS_FALL: rdMux = fallQ;
			OFS_FLTCFG: rdMux = {5'h00, fltCfgQ};
			OFS_DTR: rdMux = {8'h00, dtrQ};
			OFS_ALERTEN: rdMux = {4'h0, alertEnQ};
			OFS_STATUS: rdMux = {4'h0, statusQ};
			OFS_STATE: rdMux = {7'h00, enPrevQ, syncLockEn, powerStageEn,
				retryCntQ, stateQ};
			OFS_IOUT: rdMux = {4'h0, ioutQ};
			OFS_OCLIM: rdMux = {4'h0, ocLimQ};
			default: rdMux = 16'h0000;
		endcase
	end

	// Read data appear the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= '0;
			alertOut <= 1'b0;
			alertOe <= 1'b0;
		end else begin
			rdData <= (rdStb && mapped) ? rdMux : 16'h0000;
			alertOut <= 1'b0;
			alertOe <= |(statusQ & alertEnQ);
		end
	end

	// ==========================================================
	// Submodules
	bsfm_ramp #(.VW(VW), .SW(16)) uRamp (
		.clk(clk),
		.rst(rst),
		.load(rampLoad),
		.loadVal('0),
		.run(rampRun),
		.target(rampTarget),
		.stepCycles((stateQ == ST_FALL) ? fallQ : riseQ),
		.level(rampLevel),
		.atTarget(rampAt)
	);

	bsfm_timer #(.W(16)) uDtf (
		.clk(clk),
		.rst(rst),
		.tick(msTick),
		.start(dtfStart),
		.count(16'(dtfMs)),
		.busy(),
		.done(dtfDone)
	);

	bsfm_timer #(.W(16)) uDtr (
		.clk(clk),
		.rst(rst),
		.tick(msTick),
		.start(dtrStart),
		.count(dtrEff),
		.busy(),
		.done(dtrDone)
	);

	bsfm_timer #(.W(16)) uLock (
		.clk(clk),
		.rst(rst),
		.tick(msTick),
		.start(lockStart),
		.count(LOCK_WINDOW_MS),
		.busy(lockBusy),
		.done()
	);
endmodule

// [rtl/bsfm_pkg.sv]
// Shared constants and types of the buck sequencing and fault manager.
package bsfm_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
	localparam logic [15:0] LOCK_WINDOW_MS = 16'h0001;
	localparam logic [15:0] DTR_FACTOR = 16'h0064;
	localparam int PWM_HALF_CYCLES = 100;

	// ==========================================================
	// Widths
	localparam int AW = 4;
	localparam int DW = 16;
	localparam int VW = 12;
	localparam int NFLT = 6;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_FEATURE = 4'h1;
	localparam logic [3:0] OFS_PINSETUP = 4'h2;
	localparam logic [3:0] OFS_VOUT = 4'h3;
	localparam logic [3:0] OFS_VOFF = 4'h4;
	localparam logic [3:0] OFS_RISE = 4'h5;
	localparam logic [3:0] OFS_FALL = 4'h6;
	localparam logic [3:0] OFS_FLTCFG = 4'h7;
	localparam logic [3:0] OFS_DTR = 4'h8;
	localparam logic [3:0] OFS_ALERTEN = 4'h9;
	localparam logic [3:0] OFS_STATUS = 4'hA;
	localparam logic [3:0] OFS_STATE = 4'hB;
	localparam logic [3:0] OFS_IOUT = 4'hC;
	localparam logic [3:0] OFS_OCLIM = 4'hD;

	// ==========================================================
	// Field positions
	localparam int CTRL_OPON = 0;
	localparam int CTRL_USECMD = 1;
	localparam int CTRL_RESYNC = 2;
	localparam int FEAT_TRACK = 0;
	localparam int FLT_RETRY_LSB = 0;
	localparam int FLT_DTF_LSB = 3;

	// ==========================================================
	// Reset values
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [VW-1:0] RST_VOUT = 12'h000;
	localparam logic [VW-1:0] RST_VOFF = 12'h000;
	localparam logic [15:0] RST_STEP = 16'h0010;
	localparam logic [10:0] RST_FLTCFG = 11'h000;
	localparam logic [7:0] RST_DTR = 8'h00;
	localparam logic [11:0] RST_ALERTEN = 12'hFFF;
	localparam logic [VW-1:0] RST_OCLIM = 12'hFFF;

	// ==========================================================
	// Encodings
	localparam logic [1:0] SYNC_OFF = 2'h0;
	localparam logic [1:0] SYNC_IN = 2'h1;
	localparam logic [1:0] SYNC_OUT = 2'h2;
	localparam logic [2:0] RETRY_INFINITE = 3'h7;
	localparam int FI_OC = 4;
	localparam int FI_OT = 5;

	typedef enum logic [2:0] {
		ST_OFF, ST_RISE, ST_ON, ST_FALL, ST_RETRY, ST_LATCH
	} bsfm_state_t;

endpackage

// [rtl/bsfm_timer.sv]
// Millisecond down-counter with busy level and done pulse.
`timescale 1ns/1ps
module bsfm_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic start,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	import bsfm_pkg::*;

	logic [W-1:0] cntQ;

	// ==========================================================
	// Counter
	// A start always reloads, so a stale run is simply restarted.
	always_ff @(posedge clk) begin
		if (rst) begin
			cntQ <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cntQ <= count;
				busy <= 1'b1;
			end else if (busy && cntQ == '0) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else if (busy && tick) begin
				cntQ <= cntQ - 1'b1;
			end
		end
	end
endmodule

// [rtl/bsfm_ramp.sv]
// Set-point ramp generator stepping one code per programmed interval.
`timescale 1ns/1ps
module bsfm_ramp #(
	parameter int VW = 12,
	parameter int SW = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [VW-1:0] loadVal,
	input wire logic run,
	input wire logic [VW-1:0] target,
	input wire logic [SW-1:0] stepCycles,
	output logic [VW-1:0] level,
	output logic atTarget
);
	import bsfm_pkg::*;

	logic [SW-1:0] divQ;
	logic stepNow;

	// Step once the interval has elapsed and the level is off target.
	assign atTarget = (level == target);
	assign stepNow = run && !atTarget && (divQ >= stepCycles);

	// ==========================================================
	// Ramp state
	// The step interval sets the slope, so rise and fall times are kept.
	always_ff @(posedge clk) begin
		if (rst) begin
			level <= '0;
			divQ <= '0;
		end else if (load) begin
			level <= loadVal;
			divQ <= '0;
		end else if (stepNow) begin
			level <= (level < target) ? level + 1'b1 : level - 1'b1;
			divQ <= '0;
		end else if (run && !atTarget) begin
			divQ <= divQ + 1'b1;
		end
	end
endmodule

// [tb/bsfm_chk_sva.sv]
// Port-level assertions of the sequencing and fault manager.
`timescale 1ns/1ps
module bsfm_chk_sva #(
	parameter int MS_CYCLES_P = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [bsfm_pkg::AW-1:0] addr,
	input wire logic [bsfm_pkg::DW-1:0] wrData,
	input wire logic wrStb,
	input wire logic enablePin,
	input wire logic [bsfm_pkg::VW-1:0] trackingVoltageInput,
	input wire logic [4:0] faultRaw,
	input wire logic syncOut,
	input wire logic syncOe,
	input wire logic syncLockEn,
	input wire logic [bsfm_pkg::VW-1:0] vSetpoint,
	input wire logic powerStageEn,
	input wire logic hiZ
);
	import bsfm_pkg::*;
	// ==========================================================
	// Setting shadows
	localparam int LOCK_MAX = 2 * MS_CYCLES_P + 4;
	logic dtfZero_q, useCmd_q, trackEn_q;
	int lockCnt_q;
	wire logic fltWr = wrStb && addr == OFS_FLTCFG;
	wire logic ctlWr = wrStb && addr == OFS_CTRL;
	wire logic featWr = wrStb && addr == OFS_FEATURE;

	// Mirrors the settings that qualify the checks and times the lock window.
	always_ff @(posedge clk) begin
		if (rst) begin
			dtfZero_q <= 1'b1;
			useCmd_q <= 1'b0;
			trackEn_q <= 1'b0;
			lockCnt_q <= 0;
		end else begin
			if (fltWr) dtfZero_q <= wrData[10:3] == 8'h00;
			if (ctlWr) useCmd_q <= wrData[CTRL_USECMD];
			if (featWr) trackEn_q <= wrData[FEAT_TRACK];
			lockCnt_q <= syncLockEn ? lockCnt_q + 1 : 0;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_trackLow;
		trackEn_q && trackingVoltageInput == 12'h000 && vSetpoint == 12'h000;
	endsequence

	a_hiz_mirror: assert property (hiZ == !powerStageEn)
		else $error("hiZ does not mirror the stage enable");
	a_fault_cutoff: assert property (
		dtfZero_q && faultRaw[3:0] != 4'h0 |-> ##[1:3] !powerStageEn)
		else $error("stage still switching after a fault");
	a_soft_off: assert property (
		$rose(faultRaw[4]) && faultRaw[3:0] == 4'h0 && powerStageEn && vSetpoint > 12'h004
		|=> (vSetpoint != 12'h000) [*3])
		else $error("over-temperature did not ramp down");
	a_pin_gates: assert property ($rose(powerStageEn) && !useCmd_q |-> enablePin)
		else $error("stage started without the enable pin");
	a_track_hold: assert property (s_trackLow [*2] |=> vSetpoint == 12'h000)
		else $error("low tracking input did not hold the output off");
	a_sync_quiet: assert property (!syncOe |-> !syncOut)
		else $error("sync clock driven while not in output mode");
	a_sync_dir: assert property (!(syncOe && syncLockEn))
		else $error("sync pin both driven and locking");
	a_lock_window: assert property (lockCnt_q <= LOCK_MAX)
		else $error("lock window stayed open too long");
endmodule

// [tb/bsfm_host_model.sv]
// Bus host and enable pin model on the far side of the manager.
`timescale 1ns/1ps
module bsfm_host_model (
	input wire logic clk,
	output logic [bsfm_pkg::AW-1:0] addr,
	output logic [bsfm_pkg::DW-1:0] wrData,
	output logic wrStb,
	output logic rdStb,
	input wire logic [bsfm_pkg::DW-1:0] rdData,
	output logic enablePin,
	output logic syncIn
);
	import bsfm_pkg::*;
	logic [1:0] div_q = 2'h0;

	// Idle levels at time zero.
	initial begin
		addr = 4'h0;
		wrData = 16'h0000;
		wrStb = 1'b0;
		rdStb = 1'b0;
		enablePin = 1'b0;
		syncIn = 1'b0;
	end

	// The external switching clock runs from time zero, ahead of any enable.
	always @(posedge clk) begin
		div_q <= div_q + 2'h1;
		syncIn <= div_q[1];
	end

	// One write cycle; the data lines are scrambled once it is over.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		wrData <= ~d;
	endtask

	// One read cycle; the data is taken in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		d = rdData;
	endtask

	// Sets the enable pin level.
	task automatic pin(input logic v);
		@(posedge clk);
		enablePin <= v;
	endtask
endmodule

// [tb/tb_buck_sequencing_fault_manager.sv]
// Self-checking bench of the sequencing and fault manager.
`timescale 1ns/1ps
module tb_buck_sequencing_fault_manager;
	import bsfm_pkg::*;
	// ==========================================================
	// Signals
	localparam int MSC = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [AW-1:0] addr;
	logic [DW-1:0] wrData, rdData, rv;
	logic wrStb, rdStb, enablePin, syncIn, syncOut, syncOe, syncLockEn;
	logic powerStageEn, hiZ, alertOut, alertOe;
	logic [VW-1:0] trackingVoltageInput, voutSense, currentSample, vSetpoint;
	logic [4:0] faultRaw;
	logic [NFLT-1:0] warnRaw;
	int n_fail = 0;
	int n_compared = 0;

	// Half-period toggle gives the 200 MHz clock.
	always #2.5 clk = ~clk;

	bsfm_host_model host (.clk, .addr, .wrData, .wrStb, .rdStb, .rdData, .enablePin, .syncIn);

	bsfm_top #(.MS_CYCLES_P(MSC), .PWM_HALF_P(4)) dut (.clk, .rst, .addr, .wrData, .wrStb,
		.rdStb, .rdData, .enablePin, .trackingVoltageInput, .voutSense, .currentSample,
		.faultRaw, .warnRaw, .syncIn, .syncOut, .syncOe, .syncLockEn, .vSetpoint,
		.powerStageEn, .hiZ, .alertOut, .alertOe);

	// ==========================================================
	// Helpers
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: flag %b, want %b", $time, g, e);
		end
	endtask
	task automatic chkv(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: value %h, want %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		host.rd(a, rv);
		chkv(rv & m, e);
	endtask
	task automatic wait_pse(input logic v, input int n);
		for (int i = 0; i < n && powerStageEn !== v; i++) cyc(1);
		chk1(powerStageEn, v);
	endtask
	task automatic wait_set(input logic [11:0] v, input int n);
		for (int i = 0; i < n && vSetpoint !== v; i++) cyc(1);
		chkv({4'h0, vSetpoint}, {4'h0, v});
	endtask
	task automatic recycle;
		host.pin(1'b0);
		host.pin(1'b1);
		wait_pse(1'b1, 300);
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_defaults;
		rdchk(OFS_ALERTEN, 16'hFFFF, 16'h0FFF);
		rdchk(OFS_FEATURE, 16'hFFFF, 16'h0000);
		rdchk(OFS_PINSETUP, 16'hFFFF, 16'h0000);
		rdchk(OFS_FLTCFG, 16'hFFFF, 16'h0000);
		host.wr(OFS_STATE, 16'hFFFF);
		rdchk(OFS_STATE, 16'hFFFF, 16'h0000);
		rdchk(4'hE, 16'hFFFF, 16'h0000);
		host.wr(OFS_CTRL, 16'h0001);
		cyc(10);
		chk1(powerStageEn, 1'b0);
		host.wr(OFS_CTRL, 16'h0002);
		host.pin(1'b1);
		cyc(10);
		chk1(powerStageEn, 1'b0);
		host.wr(OFS_CTRL, 16'h0000);
		wait_pse(1'b1, 20);
		host.pin(1'b0);
		wait_pse(1'b0, 20);
	endtask
	task automatic t_sync;
		int n;
		logic p;
		host.wr(OFS_PINSETUP, 16'h0002);
		cyc(2);
		chk1(syncOe, 1'b1);
		n = 0;
		p = syncOut;
		for (int i = 0; i < 24; i++) begin
			cyc(1);
			if (syncOut !== p) n++;
			p = syncOut;
		end
		chk1(n >= 5, 1'b1);
		host.wr(OFS_PINSETUP, 16'h0001);
		host.pin(1'b1);
		cyc(3);
		chk1(syncLockEn, 1'b1);
		cyc(2 * MSC + 4);
		chk1(syncLockEn, 1'b0);
		host.wr(OFS_CTRL, 16'h0004);
		cyc(3);
		chk1(syncLockEn, 1'b1);
		host.wr(OFS_PINSETUP, 16'h0000);
		cyc(2);
		chk1(syncLockEn | syncOe, 1'b0);
		host.pin(1'b0);
		wait_pse(1'b0, 100);
	endtask
	task automatic t_prebias;
		host.wr(OFS_VOUT, 16'h0080);
		host.wr(OFS_VOFF, 16'h0020);
		host.wr(OFS_RISE, 16'h0001);
		voutSense <= 12'h040;
		host.pin(1'b1);
		wait_pse(1'b1, 300);
		chk1(vSetpoint >= 12'h040, 1'b1);
		wait_set(12'h080, 200);
		host.pin(1'b0);
		wait_pse(1'b0, 3000);
		wait_set(12'h020, 1);
		chk1(hiZ, 1'b1);
	endtask
	task automatic t_track;
		host.wr(OFS_FEATURE, 16'h0001);
		host.pin(1'b1);
		cyc(100);
		wait_set(12'h000, 1);
		trackingVoltageInput <= 12'h035;
		cyc(150);
		wait_set(12'h035, 1);
		trackingVoltageInput <= 12'h000;
		host.pin(1'b0);
		wait_set(12'h000, 1500);
		host.wr(OFS_FEATURE, 16'h0000);
		voutSense <= 12'h000;
	endtask
	task automatic t_fault;
		host.pin(1'b1);
		wait_set(12'h080, 300);
		warnRaw <= 6'h3F;
		cyc(3);
		chk1(powerStageEn & alertOe, 1'b1);
		chk1(alertOut, 1'b0);
		warnRaw <= 6'h00;
		host.wr(OFS_ALERTEN, 16'h0000);
		host.wr(OFS_STATUS, 16'h0FFF);
		warnRaw <= 6'h01;
		cyc(3);
		chk1(alertOe, 1'b0);
		rdchk(OFS_STATUS, 16'h0FFF, 16'h0001);
		warnRaw <= 6'h00;
		host.wr(OFS_ALERTEN, 16'h0FFF);
		faultRaw <= 5'h10;
		cyc(50);
		chk1(powerStageEn, 1'b1);
		wait_pse(1'b0, 2000);
		wait_set(12'h020, 1);
		rdchk(OFS_STATE, 16'h0007, 16'h0005);
		faultRaw <= 5'h00;
		recycle();
		faultRaw <= 5'h0E;
		cyc(4);
		chk1(powerStageEn, 1'b0);
		faultRaw <= 5'h00;
		recycle();
		host.wr(OFS_OCLIM, 16'h0800);
		currentSample <= 12'hFFF;
		cyc(1);
		currentSample <= 12'h010;
		cyc(4);
		chk1(powerStageEn, 1'b0);
		rdchk(OFS_STATUS, 16'h0400, 16'h0400);
		rdchk(OFS_IOUT, 16'h0800, 16'h0000);
		recycle();
	endtask
	task automatic t_retry;
		host.wr(OFS_FLTCFG, 16'h0017);
		faultRaw <= 5'h01;
		cyc(10);
		faultRaw <= 5'h00;
		cyc(60);
		chk1(powerStageEn, 1'b1);
		faultRaw <= 5'h01;
		cyc(15);
		chk1(powerStageEn, 1'b1);
		cyc(55);
		chk1(powerStageEn, 1'b0);
		faultRaw <= 5'h00;
		cyc(3830);
		chk1(powerStageEn, 1'b0);
		wait_pse(1'b1, 400);
		faultRaw <= 5'h01;
		cyc(32300);
		rdchk(OFS_STATE, 16'h0007, 16'h0004);
		faultRaw <= 5'h00;
		wait_pse(1'b1, 4400);
		host.wr(OFS_FLTCFG, 16'h0012);
		faultRaw <= 5'h01;
		cyc(4200);
		rdchk(OFS_STATE, 16'h0007, 16'h0004);
		cyc(8200);
		rdchk(OFS_STATE, 16'h0007, 16'h0005);
		faultRaw <= 5'h00;
		recycle();
	endtask

	// Inputs start idle; the sequence begins after four reset cycles.
	initial begin
		trackingVoltageInput <= 12'h000;
		voutSense <= 12'h000;
		currentSample <= 12'h000;
		faultRaw <= 5'h00;
		warnRaw <= 6'h00;
		cyc(4);
		rst <= 1'b0;
		t_defaults();
		t_sync();
		t_prebias();
		t_track();
		t_fault();
		t_retry();
		report_and_stop();
	end

	// Watchdog that cuts a hang short.
	initial begin
		cyc(70000);
		n_fail++;
		report_and_stop();
	end
endmodule

bind bsfm_top bsfm_chk_sva #(.MS_CYCLES_P(MS_CYCLES_P)) chk (.clk, .rst, .addr, .wrData,
	.wrStb, .enablePin, .trackingVoltageInput, .faultRaw, .syncOut, .syncOe, .syncLockEn,
	.vSetpoint, .powerStageEn, .hiZ);
